/* core/pss_pkg.sv */
/*
  pss_pkg: constants, codes and types for the pid source selector.
  assumes a single 25 MHz clock and a 1 ms control tick made from it.
*/
// Notes on behaviour
// - methods 1,2 output frequency; 3,4 compensation
// - methods 1,3 derivative on deviation, else feedback
// - contact code 19 on disables pid
// - code 30 or stop clears the integral
// - code 31 on holds the integral
// - code 34 on ramps the target when it is the frequency reference
// - code 35 on inverts input polarity
// - analog in2 to feedback (b) or target (c)
// - default target is the selected frequency reference
// - serial select bit 1 picks serial target
// - pulse selector 2 picks pulse as target
// - fixed setpoint enable picks stored setpoint
// - pulse selector 1 picks pulse as feedback
// - target taken in hertz, used as percent
// - monitors in 0.01 percent, 10 V full
// - zero derivative time skips derivative
package pss_pkg;
  localparam int          CLK_HZ         = 25000000;
  localparam int          TICK_TIME_US   = 1000;
  localparam int          TICK_CYCLES    = TICK_TIME_US * (CLK_HZ / 1000000);
  localparam int          RAMP_UNIT_MS   = 100;
  localparam int          TICKS_PER_UNIT = (RAMP_UNIT_MS * 1000) / TICK_TIME_US;
  localparam logic [15:0] PCT_FULL       = 16'h2710;
  localparam logic [15:0] AIN_FULL       = 16'h0fff;
  // contact, analog and pulse input function codes, then pid method codes
  localparam logic [7:0]  FC_PID_DISABLE = 8'h13;
  localparam logic [7:0]  FC_INT_RESET   = 8'h1e;
  localparam logic [7:0]  FC_INT_HOLD    = 8'h1f;
  localparam logic [7:0]  FC_SOFT_START  = 8'h22;
  localparam logic [7:0]  FC_INV_INPUT   = 8'h23;
  localparam logic [4:0]  AIN2_FEEDBACK  = 5'h0b;
  localparam logic [4:0]  AIN2_TARGET    = 5'h0c;
  localparam logic [1:0]  PULSE_FEEDBACK = 2'h1;
  localparam logic [1:0]  PULSE_TARGET   = 2'h2;
  localparam logic [2:0]  METHOD_FQ_DEV  = 3'h1;
  localparam logic [2:0]  METHOD_FQ_FB   = 3'h2;
  localparam logic [2:0]  METHOD_CP_DEV  = 3'h3;
  localparam logic [2:0]  METHOD_CP_FB   = 3'h4;
  // serial register map and reset values
  localparam logic [15:0] REG_SERIAL_TGT = 16'h0006;
  localparam logic [15:0] REG_SRC_SELECT = 16'h000f;
  localparam int          SER_TGT_BIT    = 1;
  localparam logic [15:0] RST_SERIAL_TGT = 16'h0000;
  localparam logic [15:0] RST_SRC_SELECT = 16'h0000;

  typedef enum logic [2:0] {
    SRC_DEFAULT = 3'b000,
    SRC_ANALOG  = 3'b001,
    SRC_PULSE   = 3'b010,
    SRC_SERIAL  = 3'b011,
    SRC_FIXED   = 3'b100
  } pss_src_t;
endpackage : pss_pkg

/* core/pss_top.sv */
/*
  pss_top: pid method decode, target and feedback routing, contact
  functions, soft-start ramp, monitors and the two serial registers.
  assumes all inputs synchronous to ref_clk; pid arithmetic lives outside.
*/
`timescale 1ns/10ps
`default_nettype none
module pss_top #(
  parameter int TICK_CYCLES = pss_pkg::TICK_CYCLES
) (
  input  wire logic             ref_clk,                // 25 MHz
  input  wire logic             arst_n,                 // async reset
  input  wire logic [2:0]       pid_method_select,      // 0 off, 1..4
  input  wire logic [4:0]       analog_in2_function,    // b fb, c target
  input  wire logic [1:0]       pulse_input_function,   // 1 fb, 2 target
  input  wire logic             fixed_setpoint_enable,  // stored setpoint
  input  wire logic [15:0]      fixed_setpoint_value,   // 0.01 %
  input  wire logic [4:0]       contact_in,             // contact levels
  input  wire logic [4:0][7:0]  contact_input_function, // code per contact
  input  wire logic [15:0]      freq_ref,               // 0.01 Hz
  input  wire logic [15:0]      max_freq,               // 0.01 Hz
  input  wire logic [15:0]      analog_in2,             // raw adc
  input  wire logic [15:0]      pulse_in,               // 0.01 %
  input  wire logic [15:0]      d_time,                 // 0.01 s
  input  wire logic [7:0]       ramp_time,              // 0.1 s
  input  wire logic             drive_run,              // drive running
  input  wire logic signed [16:0] pid_out,              // 0.01 %
  input  wire logic [1:0]       mon_sel,                // analog monitor
  input  wire logic             ser_wr,                 // serial write
  input  wire logic             ser_rd,                 // serial read
  input  wire logic [15:0]      ser_addr,               // register number
  input  wire logic [15:0]      ser_wdata,              // write data
  output logic [15:0]           ser_rdata,              // read data
  output logic                  ser_ack,                // access done
  output logic                  ctrl_tick,              // 1 ms pulse
  output logic                  pid_enable,             // pid active
  output logic                  pid_as_freq,            // output is freq
  output logic                  pid_compensate,         // output added
  output logic                  d_on_feedback,          // d on feedback
  output logic                  d_enable,               // d computed
  output logic                  integ_clear,            // clear integral
  output logic                  integ_hold,             // freeze integral
  output logic                  invert_input,           // polarity swap
  output logic                  softstart_active,       // ramping target
  output pss_pkg::pss_src_t     tgt_source,             // chosen target
  output logic signed [16:0]    d_input,                // d term input
  output logic [15:0]           mon_feedback,           // 0.01 %
  output logic signed [16:0]    mon_pid_input,          // 0.01 %
  output logic signed [16:0]    mon_pid_output,         // 0.01 %
  output logic [15:0]           mon_setpoint,           // 0.01 %
  output logic signed [16:0]    mon_analog_mv           // 10000 = 10 V
);
  import pss_pkg::*;

  // scale to 0.01 % of full, clamped; division kept combinational
  function automatic logic [15:0] to_pct(input logic [15:0] v, input logic [15:0] full);
    logic [31:0] q;
    q = (full == 16'h0000) ? 32'h0 : ({16'h0, v} * {16'h0, PCT_FULL}) / {16'h0, full};
    to_pct = (q > {16'h0, PCT_FULL}) ? PCT_FULL : q[15:0];
  endfunction : to_pct

  function automatic logic func_on(input logic [4:0] pins, input logic [4:0][7:0] fn,
                                   input logic [7:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 5; i++) begin
      hit = hit | (pins[i] & (fn[i] == code));
    end
    func_on = hit;
  endfunction : func_on

  logic [15:0] cnt;
  logic [15:0] serial_tgt;
  logic [15:0] src_select;

  wire         f19      = func_on(contact_in, contact_input_function, FC_PID_DISABLE);
  wire         f30      = func_on(contact_in, contact_input_function, FC_INT_RESET);
  wire         f31      = func_on(contact_in, contact_input_function, FC_INT_HOLD);
  wire         f34      = func_on(contact_in, contact_input_function, FC_SOFT_START);
  wire         f35      = func_on(contact_in, contact_input_function, FC_INV_INPUT);
  wire         tick_due = (cnt == 16'(TICK_CYCLES - 1));
  wire [15:0]  ref_pct  = to_pct(freq_ref, max_freq);
  wire [15:0]  ain_pct  = to_pct(analog_in2, AIN_FULL);
  wire [15:0]  pls_pct  = to_pct(pulse_in, PCT_FULL);
  wire [15:0]  ser_pct  = to_pct(serial_tgt, PCT_FULL);
  wire [15:0]  fix_pct  = to_pct(fixed_setpoint_value, PCT_FULL);
  wire         ser_en   = src_select[SER_TGT_BIT];
  wire         m_valid  = (pid_method_select >= METHOD_FQ_DEV) &&
                          (pid_method_select <= METHOD_CP_FB);
  wire         next_en  = m_valid & ~f19;
  wire         next_freq = next_en & ((pid_method_select == METHOD_FQ_DEV) |
                                      (pid_method_select == METHOD_FQ_FB));
  wire         next_comp = next_en & ((pid_method_select == METHOD_CP_DEV) |
                                      (pid_method_select == METHOD_CP_FB));
  wire         next_dfb = (pid_method_select == METHOD_FQ_FB) |
                          (pid_method_select == METHOD_CP_FB);
  wire         next_den = next_en & (d_time != 16'h0000);
  wire         next_clr = f30 | (next_en & ~drive_run);
  wire         next_hold = f31 & ~next_clr;

  // disabled pid falls back to the plain frequency reference
  pss_src_t    next_src;
  assign next_src = !next_en ? SRC_DEFAULT :
                    fixed_setpoint_enable ? SRC_FIXED :
                    ser_en ? SRC_SERIAL :
                    (pulse_input_function == PULSE_TARGET) ? SRC_PULSE :
                    (analog_in2_function == AIN2_TARGET) ? SRC_ANALOG :
                    SRC_DEFAULT;

  wire [15:0]  raw_tgt = (next_src == SRC_FIXED)  ? fix_pct :
                         (next_src == SRC_SERIAL) ? ser_pct :
                         (next_src == SRC_PULSE)  ? pls_pct :
                         (next_src == SRC_ANALOG) ? ain_pct : ref_pct;
  wire [15:0]  fb_pct  = (pulse_input_function == PULSE_FEEDBACK) ? pls_pct :
                         (analog_in2_function == AIN2_FEEDBACK) ? ain_pct : 16'h0000;

  // ramp works only on the frequency-reference target
  wire         ss_on    = f34 & next_en & (next_src == SRC_DEFAULT);
  wire [31:0]  ramp_den = 32'(ramp_time) * 32'(TICKS_PER_UNIT);
  wire [31:0]  ramp_q   = (ramp_den == 32'h0) ? {16'h0, PCT_FULL} : {16'h0, PCT_FULL} / ramp_den;
  wire [15:0]  ramp_step = (ramp_q == 32'h0) ? 16'h0001 : ramp_q[15:0];
  wire [15:0]  up_gap   = raw_tgt - mon_setpoint;
  wire [15:0]  dn_gap   = mon_setpoint - raw_tgt;
  wire [15:0]  next_tgt = !ss_on ? raw_tgt :
                          (raw_tgt > mon_setpoint) ?
                            ((up_gap > ramp_step) ? mon_setpoint + ramp_step : raw_tgt) :
                            ((dn_gap > ramp_step) ? mon_setpoint - ramp_step : raw_tgt);
  wire signed [16:0] tgt_s = {1'b0, next_tgt};
  wire signed [16:0] fb_s  = {1'b0, fb_pct};
  wire signed [16:0] next_dev = f35 ? (fb_s - tgt_s) : (tgt_s - fb_s);
  wire signed [16:0] next_din = next_dfb ? fb_s : next_dev;
  wire signed [16:0] next_mon = (mon_sel == 2'h0) ? fb_s :
                                (mon_sel == 2'h1) ? next_dev :
                                (mon_sel == 2'h2) ? pid_out : tgt_s;
  wire         hit_tgt  = (ser_addr == REG_SERIAL_TGT);
  wire         hit_sel  = (ser_addr == REG_SRC_SELECT);
  wire [15:0]  next_rdata = hit_tgt ? serial_tgt : hit_sel ? src_select : 16'h0000;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt       <= 16'h0000;
      ctrl_tick <= 1'b0;
    end else begin
      cnt       <= tick_due ? 16'h0000 : cnt + 16'h0001;
      ctrl_tick <= tick_due;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_tgt <= RST_SERIAL_TGT;
      src_select <= RST_SRC_SELECT;
      ser_rdata  <= 16'h0000;
      ser_ack    <= 1'b0;
    end else begin
      if (ser_wr && hit_tgt) serial_tgt <= ser_wdata;
      if (ser_wr && hit_sel) src_select <= ser_wdata;
      if (ser_rd) ser_rdata <= next_rdata;
      ser_ack <= ser_wr | ser_rd;
    end
  end

  // mode bits follow every clock, so contact changes act at once
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pid_enable       <= 1'b0;
      pid_as_freq      <= 1'b0;
      pid_compensate   <= 1'b0;
      d_on_feedback    <= 1'b0;
      d_enable         <= 1'b0;
      integ_clear      <= 1'b0;
      integ_hold       <= 1'b0;
      invert_input     <= 1'b0;
      softstart_active <= 1'b0;
      tgt_source       <= SRC_DEFAULT;
    end else begin
      pid_enable       <= next_en;
      pid_as_freq      <= next_freq;
      pid_compensate   <= next_comp;
      d_on_feedback    <= next_dfb;
      d_enable         <= next_den;
      integ_clear      <= next_clr;
      integ_hold       <= next_hold;
      invert_input     <= f35;
      softstart_active <= ss_on;
      tgt_source       <= next_src;
    end
  end

  // values move on the control tick only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mon_setpoint   <= 16'h0000;
      mon_feedback   <= 16'h0000;
      mon_pid_input  <= 17'sh00000;
      mon_pid_output <= 17'sh00000;
      d_input        <= 17'sh00000;
      mon_analog_mv  <= 17'sh00000;
    end else if (tick_due) begin
      mon_setpoint   <= next_tgt;
      mon_feedback   <= fb_pct;
      mon_pid_input  <= next_dev;
      mon_pid_output <= pid_out;
      d_input        <= next_din;
      mon_analog_mv  <= next_mon;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_method_freq: assert property (m_valid && !f19 && pid_method_select <= METHOD_FQ_FB
    |=> pid_as_freq && !pid_compensate) else $error("method 1/2 not frequency");
  a_deriv_source: assert property (tick_due && next_dfb |=> d_input == {1'b0, mon_feedback})
    else $error("derivative input not feedback");
  a_pid_disable: assert property (f19 |=> !pid_enable && tgt_source == SRC_DEFAULT)
    else $error("disable contact ignored");
  a_integ_clear: assert property (f30 |=> integ_clear && !integ_hold)
    else $error("integral not cleared");
  a_integ_hold: assert property (f31 && !next_clr |=> integ_hold)
    else $error("integral not held");
  a_ramp_step: assert property (tick_due && ss_on && raw_tgt > mon_setpoint
    |=> mon_setpoint > $past(mon_setpoint) && mon_setpoint <= $past(raw_tgt))
    else $error("soft start did not step");
  a_input_invert: assert property (tick_due && f35
    |=> mon_pid_input == $signed({1'b0, mon_feedback}) - $signed({1'b0, mon_setpoint}))
    else $error("input polarity not inverted");
  a_fixed_prio: assert property (next_en && fixed_setpoint_enable |=> tgt_source == SRC_FIXED)
    else $error("fixed setpoint lost priority");
  a_d_skip: assert property (d_time == 16'h0000 |=> !d_enable)
    else $error("derivative not skipped");
  a_serial_ack: assert property (ser_wr && hit_sel ##1 1'b1
    |-> ser_ack && src_select == $past(ser_wdata)) else $error("serial write lost");
endmodule : pss_top
`default_nettype wire

/* sim/pss_serial_master.sv */
/*
  pss_serial_master: serial master model that writes and reads the serial target and source select registers.
  assumes strobes are taken on a rising edge and answered by ser_ack one cycle later.
*/
`timescale 1ns/10ps
`default_nettype none
module pss_serial_master
  import pss_pkg::*;
(
  input  wire logic        ref_clk,   // bench clock
  input  wire logic        ser_ack,   // device answer
  input  wire logic [15:0] ser_rdata, // read data
  output logic             ser_wr,    // write strobe
  output logic             ser_rd,    // read strobe
  output logic [15:0]      ser_addr,  // register number
  output logic [15:0]      ser_wdata  // write data
);
  initial begin
    {ser_wr, ser_rd, ser_addr, ser_wdata} = '0;
  end
  // call just after a rising edge; lat counts cycles to the ack
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data,
                        output logic [15:0] rd, output int lat);
    lat = 0;
    ser_wr    <= wr;
    ser_rd    <= ~wr;
    ser_addr  <= addr;
    ser_wdata <= data;
    @(posedge ref_clk);
    // strobe is one cycle wide; holding it would issue a second access
    ser_wr <= 1'b0;
    ser_rd <= 1'b0;
    do begin
      @(posedge ref_clk);
      lat++;
    end while (ser_ack !== 1'b1 && lat < 8);
    rd = ser_rdata;
    // released lines change pattern so a stale value is never mistaken
    ser_addr  <= ~addr;
    ser_wdata <= ~data;
    // one idle edge keeps the next call out of this time step
    @(posedge ref_clk);
  endtask : access
  task automatic select_serial(input logic on, output int lat);
    logic [15:0] rd;
    access(1'b1, REG_SRC_SELECT, 16'(on) << SER_TGT_BIT, rd, lat);
  endtask : select_serial
endmodule : pss_serial_master
`default_nettype wire

/* sim/test_pss_top.sv */
/*
  test_pss_top: self-checking bench for pss_top against an integer model.
  assumes the serial master model and a shortened tick of 8 clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module test_pss_top;
  import pss_pkg::*;
  localparam int TK = 8;
  logic               ref_clk, arst_n, fixed_setpoint_enable, drive_run, ser_wr, ser_rd;
  logic [2:0]         pid_method_select;
  logic [4:0]         analog_in2_function, contact_in, ex;
  logic [1:0]         pulse_input_function, mon_sel;
  logic [15:0]        fixed_setpoint_value, freq_ref, max_freq, analog_in2, pulse_in, d_time;
  logic [15:0]        ser_addr, ser_wdata, ser_rdata, mon_feedback, mon_setpoint, rd;
  logic [4:0][7:0]    contact_input_function, cf;
  logic [7:0]         ramp_time;
  logic signed [16:0] pid_out, d_input, mon_pid_input, mon_pid_output, mon_analog_mv;
  logic               ser_ack, ctrl_tick, pid_enable, pid_as_freq, pid_compensate, d_enable;
  logic               d_on_feedback, integ_clear, integ_hold, invert_input, softstart_active;
  pss_src_t           tgt_source;
  logic [7:0]         codes [5] = '{FC_PID_DISABLE, FC_INT_RESET, FC_INT_HOLD, FC_SOFT_START,
                                    FC_INV_INPUT};
  int                 mismatches = 0, checks_done = 0, k, lat, sp, fb, po, pi, mv, rt, st;
  pss_top #(.TICK_CYCLES(TK)) dut (
    .ref_clk, .arst_n, .pid_method_select, .analog_in2_function, .pulse_input_function,
    .fixed_setpoint_enable, .fixed_setpoint_value, .contact_in, .contact_input_function,
    .freq_ref, .max_freq, .analog_in2, .pulse_in, .d_time, .ramp_time, .drive_run, .pid_out,
    .mon_sel, .ser_wr, .ser_rd, .ser_addr, .ser_wdata, .ser_rdata, .ser_ack, .ctrl_tick,
    .pid_enable, .pid_as_freq, .pid_compensate, .d_on_feedback, .d_enable, .integ_clear,
    .integ_hold, .invert_input, .softstart_active, .tgt_source, .d_input, .mon_feedback,
    .mon_pid_input, .mon_pid_output, .mon_setpoint, .mon_analog_mv);
  pss_serial_master master (.ref_clk, .ser_ack, .ser_rdata, .ser_wr, .ser_rd, .ser_addr,
                            .ser_wdata);
  function automatic int model_src(input int c);
    return c[0] ? 4 : c[1] ? 3 : c[2] ? 2 : c[3] ? 1 : 0;
  endfunction : model_src
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle
  // second tick is the first one surely computed from the new inputs
  task automatic tick_wait;
    int n;
    n = 0;
    repeat (2) begin
      @(posedge ref_clk);
      while (ctrl_tick !== 1'b1 && n < 100) begin
        @(posedge ref_clk);
        n++;
      end
    end
    if (n >= 100) chk(17'h0, 17'h1);
    #1;
  endtask : tick_wait
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    test_done();
  end
  initial begin
    void'($urandom(32'h6c58483d));
    {arst_n, fixed_setpoint_enable, fixed_setpoint_value, contact_in, contact_input_function,
     freq_ref, analog_in2, pulse_in, d_time, ramp_time, pid_out, mon_sel} = '0;
    {analog_in2_function, pulse_input_function} = '0;
    pid_method_select = METHOD_FQ_DEV;
    drive_run = 1'b1;
    max_freq = 16'h1770;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    master.access(1'b0, REG_SERIAL_TGT, 16'h0, rd, lat);
    chk(rd, RST_SERIAL_TGT);
    master.access(1'b0, REG_SRC_SELECT, 16'h0, rd, lat);
    chk(rd, RST_SRC_SELECT);
    for (int m = 0; m < 8; m++) begin
      @(posedge ref_clk);
      pid_method_select <= 3'(m);
      settle();
      chk({pid_enable, pid_as_freq, pid_compensate},
          {m inside {[1:4]}, m < 3 && m > 0, m > 2 && m < 5});
      if (m inside {[1:4]}) chk(d_on_feedback, m == 2 || m == 4);
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      pid_method_select <= METHOD_FQ_DEV;
      d_time <= 16'(i * $urandom_range(1000, 1));
      settle();
      chk(d_enable, i != 0);
    end
    for (int i = 0; i < 5; i++) begin
      k = $urandom_range(4);
      cf = '0;
      cf[k] = codes[i];
      @(posedge ref_clk);
      contact_input_function <= cf;
      contact_in <= 5'(1 << k);
      settle();
      ex = {i != 0, i == 1, i == 2, i == 3, i == 4};
      chk({pid_enable, integ_clear, integ_hold, softstart_active, invert_input},
          ex);
      @(posedge ref_clk);
      contact_in <= ~contact_in;
      settle();
      chk({pid_enable, integ_clear, integ_hold, softstart_active, invert_input},
          17'h10);
    end
    cf = '0;
    cf[0] = FC_INV_INPUT;
    @(posedge ref_clk);
    contact_input_function <= cf;
    contact_in <= 5'h0;
    drive_run <= 1'b0;
    settle();
    chk(integ_clear, 1'b1);
    for (int c = 0; c < 16; c++) begin
      master.select_serial(c[1], lat);
      drive_run <= 1'b1;
      fixed_setpoint_enable <= c[0];
      pulse_input_function <= c[2] ? PULSE_TARGET : 2'h0;
      analog_in2_function <= c[3] ? AIN2_TARGET : 5'h00;
      settle();
      chk(tgt_source, 17'(model_src(c)));
    end
    sp = $urandom_range(10000);
    master.access(1'b1, REG_SERIAL_TGT, 16'(sp), rd, lat);
    chk(17'(lat), 17'h1);
    master.access(1'b0, REG_SERIAL_TGT, 16'h0, rd, lat);
    chk(rd, 17'(sp));
    master.access(1'b1, 16'h0010, 16'hffff, rd, lat);
    master.access(1'b0, 16'h0010, 16'h0, rd, lat);
    chk(rd, 17'h0);
    {fixed_setpoint_enable, pulse_input_function, analog_in2_function} <= '0;
    tick_wait();
    chk(mon_setpoint, 17'(sp));
    master.select_serial(1'b0, lat);
    analog_in2_function <= AIN2_TARGET;
    analog_in2 <= AIN_FULL;
    tick_wait();
    chk(mon_setpoint, PCT_FULL);
    @(posedge ref_clk);
    analog_in2_function <= AIN2_FEEDBACK;
    freq_ref <= 16'h0bb8;
    tick_wait();
    chk(tgt_source, 17'(SRC_DEFAULT));
    chk(mon_setpoint, 17'h01388);
    chk(mon_feedback, PCT_FULL);
    for (int s = 0; s < 4; s++) begin
      sp = $urandom_range(10000);
      fb = $urandom_range(10000);
      po = $urandom_range(20000) - 10000;
      @(posedge ref_clk);
      pid_method_select <= (s < 2) ? METHOD_FQ_DEV : METHOD_FQ_FB;
      {fixed_setpoint_enable, fixed_setpoint_value, pulse_in} <= {1'b1, 16'(sp), 16'(fb)};
      {pulse_input_function, pid_out, mon_sel, contact_in} <=
        {PULSE_FEEDBACK, 17'(po), 2'(s), 5'(s & 1)};
      tick_wait();
      pi = (s & 1) ? fb - sp : sp - fb;
      mv = (s == 0) ? fb : (s == 1) ? pi : (s == 2) ? po : sp;
      chk(mon_setpoint, 17'(sp));
      chk(mon_feedback, 17'(fb));
      chk(mon_pid_input, 17'(pi));
      chk(mon_pid_output, 17'(po));
      chk(mon_analog_mv, 17'(mv));
      chk(d_input, 17'((s > 1) ? fb : pi));
    end
    rt = $urandom_range(4, 1);
    st = 10000 / (rt * 100);
    @(posedge ref_clk);
    {fixed_setpoint_enable, pulse_input_function, freq_ref, contact_in} <= '0;
    tick_wait();
    chk(mon_setpoint, 17'h0);
    cf[0] = FC_SOFT_START;
    @(posedge ref_clk);
    {contact_input_function, contact_in, ramp_time, freq_ref} <= {cf, 5'h01, 8'(rt), max_freq};
    tick_wait();
    chk(softstart_active, 1'b1);
    // tick phase unknown: the first wait may hold one or two steps
    chk(17'(mon_setpoint == st || mon_setpoint == 2 * st), 17'h1);
    sp = mon_setpoint;
    tick_wait();
    chk(mon_setpoint, 17'(sp + 2 * st));
    test_done();
  end
endmodule : test_pss_top
`default_nettype wire
